/* File: src/xcr_pkg.sv */
package xcr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PART_LOW   = 10'h000;
  localparam logic [9:0] IDX_REV_DIGIT  = 10'h001;
  localparam logic [9:0] IDX_CHIP_CFG   = 10'h002;
  localparam logic [9:0] IDX_RX_PWR     = 10'h003;
  localparam logic [9:0] IDX_RX_MASK    = 10'h004;
  localparam logic [9:0] IDX_RX_STATUS  = 10'h005;
  localparam logic [9:0] IDX_CHK_PTN5   = 10'h0AC;
  localparam logic [9:0] IDX_CHK_PTN6   = 10'h0AD;
  localparam logic [9:0] IDX_CHK_PTN7   = 10'h0AE;
  localparam logic [9:0] IDX_TARGET_ERR = 10'h0AF;
  localparam logic [9:0] IDX_ERR_CNT0   = 10'h0B0;
  localparam logic [9:0] IDX_ERR_CNT1   = 10'h0B1;
  localparam logic [9:0] IDX_ERR_CNT2   = 10'h0B2;
  localparam logic [9:0] IDX_ERR_CNT3   = 10'h0B3;
  localparam logic [9:0] IDX_ERR_CNT4   = 10'h0B4;
  localparam logic [9:0] IDX_CHK_ERR    = 10'h0B5;
  localparam logic [9:0] IDX_OUT_LEVEL  = 10'h0B8;
  localparam logic [9:0] IDX_PD_GAIN    = 10'h0CD;
  localparam logic [9:0] IDX_LOOP_FILT  = 10'h0E2;
  localparam logic [9:0] IDX_IRQ_CLEAR  = 10'h0F0;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0F1;

  // Chip configuration, receive power and mask field positions
  localparam int CFG_LOS_DRIVE  = 7;
  localparam int CFG_IRQ_DRIVE  = 6;
  localparam int CFG_IRQ_EN     = 5;
  localparam int CFG_SOUT_DRIVE = 4;
  localparam int CFG_OPT_LOOP   = 2;
  localparam int CFG_HOST_LOOP  = 1;
  localparam int CFG_REF_FREQ   = 0;
  localparam int PWR_RX_DOWN    = 0;
  localparam int MASK_FIFO_BIT  = 3;

  // Reset values
  localparam logic [7:0] RST_CHIP_CFG   = 8'h08;
  localparam logic [7:0] RST_RX_PWR     = 8'h00;
  localparam logic [6:0] RST_RX_MASK    = 7'h00;
  localparam logic [6:0] RST_IRQ_ENABLE = 7'h7F;
  localparam logic [7:0] RST_CHK_PTN    = 8'hAA;
  localparam logic [7:0] RST_TARGET_ERR = 8'hFF;
  localparam logic [7:0] RST_OUT_LEVEL  = 8'hF5;
  localparam logic [7:0] RST_PD_GAIN    = 8'h8D;
  localparam logic [7:0] RST_LOOP_FILT  = 8'h1E;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Seven receive alarms, in status bit order 6 down to 0
  typedef struct packed {
    logic ref_clock_loss;
    logic signal_loss;
    logic lock_loss;
    logic fifo_fault;
    logic pattern_error_alarm;
    logic pattern_sync_loss;
    logic quality_monitor_alarm;
  } xcr_alarm_t;

  // Transmit pattern checker results
  typedef struct packed {
    logic [39:0] err_count;
    logic [7:0]  chk_err;
  } xcr_txstat_t;

  // Transmit pattern, level and loop settings
  typedef struct packed {
    logic [7:0] chk_ptn5;
    logic [7:0] chk_ptn6;
    logic [7:0] chk_ptn7;
    logic [7:0] target_err;
    logic [7:0] out_level;
    logic [7:0] pd_gain;
    logic [7:0] loop_filt;
  } xcr_txcfg_t;

endpackage

/* File: src/xcr_regs.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module xcr_regs #(
  parameter int         ADDR_W     = 12,
  parameter logic [7:0] PART_LOW   = 8'h5A, // Arbitrary identification value
  parameter logic [3:0] REVISION   = 4'h1,  // Arbitrary identification value
  parameter logic [3:0] PART_DIGIT = 4'h7   // Arbitrary identification value
) (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire xcr_pkg::xcr_alarm_t  rx_alarm,
  input  wire logic                 fifo_self_clear,
  input  wire xcr_pkg::xcr_txstat_t tx_stat,
  input  wire logic                 serial_data_bit,
  output logic                      irq,
  output logic                      irq_pin_dat,
  output logic                      irq_pin_oe_n,
  output logic                      los_pin_dat,
  output logic                      los_pin_oe_n,
  output logic                      serial_out_dat,
  output logic                      serial_out_oe_n,
  output logic                      optical_side_loopback,
  output logic                      host_side_loopback,
  output logic                      ref_freq_sel,
  output logic                      rx_powerdown,
  output xcr_pkg::xcr_txcfg_t       tx_cfg
);
  import xcr_pkg::*;

  // Word index from a byte address; low two bits ignored
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'h0;
    wide[ADDR_W-1:0] = addr;
    return wide[11:2];
  endfunction

  // Push-pull drives the level; open-drain only pulls low
  function automatic logic [1:0] pin_drive(input logic od, input logic level);
    logic [1:0] r;
    r = od ? {level, 1'b0} : {1'b0, level};
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_held_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_held_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              rd_hit_next;

  logic [7:0]        chip_cfg_reg;
  logic [7:0]        rx_pwr_reg;
  logic [6:0]        rx_mask_reg;
  logic [6:0]        rx_status_reg;
  logic [6:0]        irq_enable_reg;
  xcr_txcfg_t        tx_cfg_reg;
  logic              irq_reg;
  logic              los_level_reg;
  logic              serial_bit_reg;

  logic              wr_fire;
  logic [9:0]        wr_idx;
  logic              wr_byte0;
  logic [7:0]        wr_byte;
  logic              wr_hit;
  logic [6:0]        mask_eff;
  logic [6:0]        status_clear;
  logic              rd_fire;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx        = word_index(aw_addr_reg);
  assign wr_byte0      = wr_fire && w_strb_reg[0];
  assign wr_byte       = w_data_reg[7:0];

  // Address and data are caught independently, in either order
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Writable indices; everything else answers SLVERR
  always_comb begin
    case (wr_idx)
      IDX_CHIP_CFG, IDX_RX_PWR, IDX_RX_MASK, IDX_RX_STATUS,
      IDX_CHK_PTN5, IDX_CHK_PTN6, IDX_CHK_PTN7, IDX_TARGET_ERR,
      IDX_OUT_LEVEL, IDX_PD_GAIN, IDX_LOOP_FILT,
      IDX_IRQ_CLEAR, IDX_IRQ_ENABLE: wr_hit = 1'b1;
      default:                       wr_hit = 1'b0;
    endcase
  end

  // Response one cycle after both halves are in
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; only byte lane 0 carries data

  // Bit 3 is stored as written; software keeps it at one
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      chip_cfg_reg <= RST_CHIP_CFG;
    end else if (wr_byte0 && wr_idx == IDX_CHIP_CFG) begin
      chip_cfg_reg <= wr_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_pwr_reg <= RST_RX_PWR;
    end else if (wr_byte0 && wr_idx == IDX_RX_PWR) begin
      rx_pwr_reg <= {7'h00, wr_byte[PWR_RX_DOWN]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_mask_reg <= RST_RX_MASK;
    end else if (wr_byte0 && wr_idx == IDX_RX_MASK) begin
      rx_mask_reg <= wr_byte[6:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_enable_reg <= RST_IRQ_ENABLE;
    end else if (wr_byte0 && wr_idx == IDX_IRQ_ENABLE) begin
      irq_enable_reg <= wr_byte[6:0];
    end
  end

  // Transmit settings are storage only, handed to the datapath
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_cfg_reg <= '{RST_CHK_PTN, RST_CHK_PTN, RST_CHK_PTN, RST_TARGET_ERR,
                      RST_OUT_LEVEL, RST_PD_GAIN, RST_LOOP_FILT};
    end else if (wr_byte0) begin
      case (wr_idx)
        IDX_CHK_PTN5:   tx_cfg_reg.chk_ptn5   <= wr_byte;
        IDX_CHK_PTN6:   tx_cfg_reg.chk_ptn6   <= wr_byte;
        IDX_CHK_PTN7:   tx_cfg_reg.chk_ptn7   <= wr_byte;
        IDX_TARGET_ERR: tx_cfg_reg.target_err <= wr_byte;
        IDX_OUT_LEVEL:  tx_cfg_reg.out_level  <= wr_byte;
        IDX_PD_GAIN:    tx_cfg_reg.pd_gain    <= wr_byte;
        IDX_LOOP_FILT:  tx_cfg_reg.loop_filt  <= wr_byte;
        default:        tx_cfg_reg            <= tx_cfg_reg;
      endcase
    end
  end

  assign tx_cfg                = tx_cfg_reg;
  assign optical_side_loopback = chip_cfg_reg[CFG_OPT_LOOP];
  assign host_side_loopback    = chip_cfg_reg[CFG_HOST_LOOP];
  assign ref_freq_sel          = chip_cfg_reg[CFG_REF_FREQ];
  assign rx_powerdown          = rx_pwr_reg[PWR_RX_DOWN];

  ////////////////////////////////////////////////////////////////////////////
  // Sticky receive status and interrupt

  // Self-clearing FIFO forces the fault unmasked, read and gate alike
  always_comb begin
    mask_eff = rx_mask_reg;
    if (fifo_self_clear) begin
      mask_eff[MASK_FIFO_BIT] = 1'b0;
    end
  end

  // Zero written to status, or one written to the clear word, clears
  always_comb begin
    status_clear = 7'h00;
    if (wr_byte0 && wr_idx == IDX_RX_STATUS) begin
      status_clear = ~wr_byte[6:0];
    end else if (wr_byte0 && wr_idx == IDX_IRQ_CLEAR) begin
      status_clear = wr_byte[6:0];
    end
  end

  // A live alarm wins over a clear in the same cycle; disable wins over all
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_status_reg <= 7'h00;
    end else if (!chip_cfg_reg[CFG_IRQ_EN]) begin
      rx_status_reg <= 7'h00;
    end else begin
      rx_status_reg <= (rx_status_reg & ~status_clear) | rx_alarm;
    end
  end

  // Registered so the pin never glitches on decode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= chip_cfg_reg[CFG_IRQ_EN] &&
                 |(rx_status_reg & ~mask_eff & irq_enable_reg);
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; open-drain releases for a high level

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      los_level_reg  <= 1'b0;
      serial_bit_reg <= 1'b0;
    end else begin
      los_level_reg  <= rx_alarm.signal_loss;
      serial_bit_reg <= serial_data_bit;
    end
  end

  assign {irq_pin_oe_n, irq_pin_dat} =
         pin_drive(chip_cfg_reg[CFG_IRQ_DRIVE], irq_reg);
  assign {los_pin_oe_n, los_pin_dat} =
         pin_drive(chip_cfg_reg[CFG_LOS_DRIVE], los_level_reg);
  assign {serial_out_oe_n, serial_out_dat} =
         pin_drive(chip_cfg_reg[CFG_SOUT_DRIVE], serial_bit_reg);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign rd_fire       = s_axi_arvalid && !rvalid_reg;

  // Upper bits read zero; write-only clear word reads zero
  always_comb begin
    rdata_next  = 32'h0;
    rd_hit_next = 1'b1;
    case (word_index(s_axi_araddr))
      IDX_PART_LOW:   rdata_next[7:0] = PART_LOW;
      IDX_REV_DIGIT:  rdata_next[7:0] = {REVISION, PART_DIGIT};
      IDX_CHIP_CFG:   rdata_next[7:0] = chip_cfg_reg;
      IDX_RX_PWR:     rdata_next[7:0] = rx_pwr_reg;
      IDX_RX_MASK:    rdata_next[6:0] = mask_eff;
      IDX_RX_STATUS:  rdata_next[6:0] = rx_status_reg;
      IDX_CHK_PTN5:   rdata_next[7:0] = tx_cfg_reg.chk_ptn5;
      IDX_CHK_PTN6:   rdata_next[7:0] = tx_cfg_reg.chk_ptn6;
      IDX_CHK_PTN7:   rdata_next[7:0] = tx_cfg_reg.chk_ptn7;
      IDX_TARGET_ERR: rdata_next[7:0] = tx_cfg_reg.target_err;
      IDX_ERR_CNT0:   rdata_next[7:0] = tx_stat.err_count[7:0];
      IDX_ERR_CNT1:   rdata_next[7:0] = tx_stat.err_count[15:8];
      IDX_ERR_CNT2:   rdata_next[7:0] = tx_stat.err_count[23:16];
      IDX_ERR_CNT3:   rdata_next[7:0] = tx_stat.err_count[31:24];
      IDX_ERR_CNT4:   rdata_next[7:0] = tx_stat.err_count[39:32];
      IDX_CHK_ERR:    rdata_next[7:0] = tx_stat.chk_err;
      IDX_OUT_LEVEL:  rdata_next[7:0] = tx_cfg_reg.out_level;
      IDX_PD_GAIN:    rdata_next[7:0] = tx_cfg_reg.pd_gain;
      IDX_LOOP_FILT:  rdata_next[7:0] = tx_cfg_reg.loop_filt;
      IDX_IRQ_CLEAR:  rdata_next      = 32'h0;
      IDX_IRQ_ENABLE: rdata_next[6:0] = irq_enable_reg;
      default:        rd_hit_next     = 1'b0;
    endcase
  end

  // One read at a time; data held until rready
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit_next ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rdata_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

/* File: verif/xcr_axi_host.sv */
`timescale 1ns/1ps
module xcr_axi_host (
  input  wire logic        mclk,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus until the first request
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
           s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;

  // Both halves offered at once, each released only at the edge that takes it
  task automatic write(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Ready follows rvalid, so the slave must hold its answer a cycle
  task automatic read(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end else if (s_axi_rvalid) begin
        s_axi_rready <= 1'b1;
      end
    end
  endtask
endmodule

/* File: verif/xcr_regs_props.sv */
`timescale 1ns/1ps
module xcr_regs_props (
  input wire logic               mclk,
  input wire logic               rstn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire xcr_pkg::xcr_alarm_t rx_alarm,
  input wire logic               serial_data_bit,
  input wire logic               irq,
  input wire logic               irq_pin_dat,
  input wire logic               irq_pin_oe_n,
  input wire logic               los_pin_dat,
  input wire logic               los_pin_oe_n,
  input wire logic               serial_out_dat,
  input wire logic               serial_out_oe_n
);
  import xcr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Wire levels; a released pin is pulled high
  wire irq_lvl = irq_pin_oe_n | irq_pin_dat;
  wire los_lvl = los_pin_oe_n | los_pin_dat;
  wire so_lvl  = serial_out_oe_n | serial_out_dat;
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  a_irq_pin_level: assert property (irq_lvl == irq)
    else $error("irq pin level differs");
  a_irq_od_low: assert property (irq_pin_oe_n |-> !irq_pin_dat)
    else $error("irq pin driven high while released");
  a_los_pin_follow: assert property ($past(rstn) |-> los_lvl == $past(rx_alarm.signal_loss))
    else $error("loss pin level differs");
  a_sout_pin_follow: assert property ($past(rstn) |-> so_lvl == $past(serial_data_bit))
    else $error("serial out level differs");
  a_write_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule

bind xcr_regs xcr_regs_props u_props (.*);

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import xcr_pkg::*;
  localparam logic [7:0] PART_V = 8'h3C; // Arbitrary identification value
  localparam logic [3:0] REV_V  = 4'h2;  // Arbitrary identification value
  localparam logic [3:0] DIG_V  = 4'h9;  // Arbitrary identification value
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot = 3'h0;
  logic [2:0]  s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        irq, irq_pin_dat, irq_pin_oe_n, los_pin_dat, los_pin_oe_n, serial_out_dat;
  logic        serial_out_oe_n, optical_side_loopback, host_side_loopback;
  logic        ref_freq_sel, rx_powerdown;
  xcr_alarm_t  rx_alarm = '0;
  logic        fifo_self_clear = 1'b0;
  logic        serial_data_bit = 1'b0;
  xcr_txstat_t tx_stat = '0;
  xcr_txcfg_t  tx_cfg;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycle_count = 0;
  int          mdl [int];
  logic [7:0]  v;
  logic [1:0]  r;

  always #5 mclk = ~mclk;
  xcr_regs #(.PART_LOW(PART_V), .REVISION(REV_V), .PART_DIGIT(DIG_V)) dut (.*);
  xcr_axi_host host (.*);

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input int idx, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  rr;
    host.read(10'(idx), d, rr);
    chk("read data", {32'h0, 24'h0, exp}, {32'h0, d});
    chk("read resp", er, rr);
  endtask
  task automatic wr_chk(input int idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] rr;
    host.write(10'(idx), d, rr);
    chk("write resp", er, rr);
  endtask
  // One-cycle alarm burst, then time for status and irq to land
  task automatic pulse(input logic [6:0] a);
    @(posedge mclk) rx_alarm <= xcr_alarm_t'(a);
    @(posedge mclk) rx_alarm <= '0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic settle_irq(input logic exp);
    repeat (2) @(posedge mclk);
    chk("irq", exp, irq);
  endtask

  // Hang guard and free-running serial data
  always @(posedge mclk) begin
    serial_data_bit <= 1'($urandom);
    cycle_count <= cycle_count + 1;
    if (cycle_count == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h4c29));
    tx_stat = {$urandom, 16'($urandom)};
    mdl[IDX_PART_LOW] = PART_V;
    mdl[IDX_REV_DIGIT] = {REV_V, DIG_V};
    mdl[IDX_CHIP_CFG] = RST_CHIP_CFG;
    mdl[IDX_RX_PWR] = RST_RX_PWR;
    mdl[IDX_RX_MASK] = RST_RX_MASK;
    mdl[IDX_RX_STATUS] = 0;
    for (int k = 0; k < 3; k++) mdl[IDX_CHK_PTN5 + k] = RST_CHK_PTN;
    mdl[IDX_TARGET_ERR] = RST_TARGET_ERR;
    for (int k = 0; k < 5; k++) mdl[IDX_ERR_CNT0 + k] = tx_stat.err_count[8*k +: 8];
    mdl[IDX_CHK_ERR] = tx_stat.chk_err;
    mdl[IDX_OUT_LEVEL] = RST_OUT_LEVEL;
    mdl[IDX_PD_GAIN] = RST_PD_GAIN;
    mdl[IDX_LOOP_FILT] = RST_LOOP_FILT;
    mdl[IDX_IRQ_CLEAR] = 0;
    mdl[IDX_IRQ_ENABLE] = RST_IRQ_ENABLE;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    // Reset values, then random writes: read-only places must not move
    foreach (mdl[k]) rd_chk(k, mdl[k], RESP_OKAY);
    rd_chk(10'h3FF, 8'h00, RESP_SLVERR);
    wr_chk(10'h3FF, 8'h55, RESP_SLVERR);
    foreach (mdl[k]) begin
      v = 8'($urandom);
      if (!(k inside {IDX_CHIP_CFG, IDX_RX_PWR, IDX_RX_MASK, IDX_RX_STATUS,
                      IDX_IRQ_CLEAR, IDX_IRQ_ENABLE})) host.write(10'(k), v, r);
      if (k inside {IDX_CHK_PTN5, IDX_CHK_PTN6, IDX_CHK_PTN7, IDX_TARGET_ERR,
                    IDX_OUT_LEVEL, IDX_PD_GAIN, IDX_LOOP_FILT}) mdl[k] = v;
    end
    foreach (mdl[k]) rd_chk(k, mdl[k], RESP_OKAY);
    chk("tx_cfg", {8'(mdl[IDX_CHK_PTN5]), 8'(mdl[IDX_CHK_PTN6]), 8'(mdl[IDX_CHK_PTN7]),
                   8'(mdl[IDX_TARGET_ERR]), 8'(mdl[IDX_OUT_LEVEL]), 8'(mdl[IDX_PD_GAIN]),
                   8'(mdl[IDX_LOOP_FILT])}, tx_cfg);
    // Configuration fields; the reserved bit is always written as one
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'hFF : (8'($urandom) | 8'h08);
      wr_chk(IDX_CHIP_CFG, v, RESP_OKAY);
      repeat (4) @(posedge mclk);
      chk("loop and ref", v[2:0], {optical_side_loopback, host_side_loopback, ref_freq_sel});
      chk("sout drive", 1'b0, v[4] ? serial_out_dat : serial_out_oe_n);
      rd_chk(IDX_CHIP_CFG, v, RESP_OKAY);
    end
    wr_chk(IDX_RX_PWR, 8'hFF, RESP_OKAY);
    chk("powerdown", 1'b1, rx_powerdown);
    rd_chk(IDX_RX_PWR, 8'h01, RESP_OKAY);
    wr_chk(IDX_RX_PWR, 8'h00, RESP_OKAY);
    chk("powerdown", 1'b0, rx_powerdown);
    // Recalibration after wake-up is the receiver block's duty
    // Each alarm alone, cleared alternately by zero-write and clear register
    wr_chk(IDX_CHIP_CFG, 8'h68, RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      chk("irq", 1'b1, irq);
      chk("irq pin", 2'b10, {irq_pin_oe_n, irq_pin_dat});
      rd_chk(IDX_RX_STATUS, 8'h01 << i, RESP_OKAY);
      if (i % 2 == 1) wr_chk(IDX_IRQ_CLEAR, 8'h01 << i, RESP_OKAY);
      else wr_chk(IDX_RX_STATUS, ~(8'h01 << i), RESP_OKAY);
      settle_irq(1'b0);
    end
    wr_chk(IDX_RX_MASK, 8'h7F, RESP_OKAY);
    pulse(7'h7F);
    chk("irq", 1'b0, irq);
    rd_chk(IDX_RX_STATUS, 8'h7F, RESP_OKAY);
    @(posedge mclk) fifo_self_clear <= 1'b1;
    settle_irq(1'b1);
    rd_chk(IDX_RX_MASK, 8'h77, RESP_OKAY);
    @(posedge mclk) fifo_self_clear <= 1'b0;
    settle_irq(1'b0);
    wr_chk(IDX_RX_MASK, 8'h00, RESP_OKAY);
    wr_chk(IDX_IRQ_ENABLE, 8'h00, RESP_OKAY);
    settle_irq(1'b0);
    rd_chk(IDX_IRQ_ENABLE, 8'h00, RESP_OKAY);
    wr_chk(IDX_CHIP_CFG, 8'h28, RESP_OKAY);
    wr_chk(IDX_IRQ_ENABLE, 8'h7F, RESP_OKAY);
    settle_irq(1'b1);
    chk("irq pin", 2'b01, {irq_pin_oe_n, irq_pin_dat});
    // Global disable clears the latched bits and blocks new alarms
    wr_chk(IDX_CHIP_CFG, 8'h08, RESP_OKAY);
    settle_irq(1'b0);
    rd_chk(IDX_RX_STATUS, 8'h00, RESP_OKAY);
    pulse(7'h7F);
    chk("irq", 1'b0, irq);
    rd_chk(IDX_RX_STATUS, 8'h00, RESP_OKAY);
    // Loss pin held high in both drive styles; interrupts stay off
    @(posedge mclk) rx_alarm <= xcr_alarm_t'(7'h20);
    wr_chk(IDX_CHIP_CFG, 8'h88, RESP_OKAY);
    chk("los pin", 2'b10, {los_pin_oe_n, los_pin_dat});
    wr_chk(IDX_CHIP_CFG, 8'h08, RESP_OKAY);
    chk("los pin", 2'b01, {los_pin_oe_n, los_pin_dat});
    @(posedge mclk) rx_alarm <= '0;
    end_of_test();
  end
endmodule
